// ---- kiu_keypad_irq.sv ----
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - each enable bit makes pin a source
// - enable bit also turns pull-up on
// - latch when enabled pin falls, all high
// - edge mode ignores edge while another low
// - level mode holds while any pin low
// - level clear needs acknowledge and all high
// - vector fetch at FFDE acknowledges the request
// - acknowledge bit write-only, reads zero
// - edge after acknowledge latches again
// - service vector at FFDE and FFDF
// - edge mode acknowledge clears at once
// - reset clears request and mode bit
// - pending flag readable regardless of mask
// - enable forces pin input, overrides direction
// - active in wait/stop, request wakes CPU
// - break clear-enable lets acknowledge clear flag
// - break without clear-enable ignores acknowledge write, not vector fetch
// - status bits seven to four read zero
// - mask blocks request; reset clears mask, enables
module kiu_keypad_irq
    import kiu_pkg::*;
#(
    parameter int NUM_PINS = KIU_PIN_COUNT
) (
    input  wire logic                        clock,
    input  wire logic                        arst_n,
    input  wire kiu_pkg::kiu_bus_req_t       busReq,
    output logic [kiu_pkg::KIU_DATA_W-1:0]   rdData,
    input  wire kiu_pkg::kiu_vec_fetch_t     vecFetch,
    input  wire logic                        breakState,
    input  wire logic                        breakClearEnable,
    input  wire logic [NUM_PINS-1:0]         portDPin,
    input  wire logic [NUM_PINS-1:0]         portDDirection,
    output logic [NUM_PINS-1:0]              keyPinEnable,
    output logic [NUM_PINS-1:0]              portDOutputEnable,
    output logic                             keyIrq
);
    import kiu_pkg::*;

    generate
        if (NUM_PINS < 1 || NUM_PINS > KIU_DATA_W) begin : g_bad_width
            $error("kiu_keypad_irq: NUM_PINS must be 1 to 8");
        end
    endgenerate

    logic                  keyIrqMask;
    logic                  keyLevelSenseSelect;
    logic [NUM_PINS-1:0]   pinSync;
    logic                  anyLowPrev;
    logic                  keyReq;

    // register decode
    wire hitStatus   = (busReq.addr == KIU_OFS_STATUS_CTRL);
    wire hitEnable   = (busReq.addr == KIU_OFS_PIN_ENABLE);
    wire wrStatus    = busReq.wr && hitStatus;
    wire wrEnable    = busReq.wr && hitEnable;
    wire rdStatus    = busReq.rd && hitStatus;
    wire rdEnable    = busReq.rd && hitEnable;

    // acknowledge is a write side effect only; nothing stores it
    wire ackWrite    = wrStatus && busReq.wdata[KIU_BIT_ACK];
    wire ackAllowed  = !breakState || breakClearEnable;
    wire swAck       = ackWrite && ackAllowed;
    wire vecAck      = vecFetch.fetch && (vecFetch.addr == KIU_VEC_HI);
    wire ackEvent    = swAck || vecAck;

    wire [KIU_DATA_W-1:0] statusView;
    wire [KIU_DATA_W-1:0] enableView;
    wire [KIU_DATA_W-1:0] next_rdData;

    assign statusView = {{(KIU_UNUSED_MSB-KIU_UNUSED_LSB+1){1'b0}},
                         keyReq, 1'b0, keyIrqMask, keyLevelSenseSelect};
    assign enableView = KIU_DATA_W'(keyPinEnable);
    assign next_rdData = rdStatus ? statusView :
                         rdEnable ? enableView : KIU_READ_ZERO;

    // control registers
    // reset clears mode
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            keyIrqMask          <= KIU_RST_STATUS_CTRL[KIU_BIT_MASK];
            keyLevelSenseSelect <= KIU_RST_STATUS_CTRL[KIU_BIT_MODE];
        end else if (wrStatus) begin
            keyIrqMask          <= busReq.wdata[KIU_BIT_MASK];
            keyLevelSenseSelect <= busReq.wdata[KIU_BIT_MODE];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            keyPinEnable <= KIU_RST_PIN_ENABLE[NUM_PINS-1:0];
        end else if (wrEnable) begin
            keyPinEnable <= busReq.wdata[NUM_PINS-1:0];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdData <= KIU_READ_ZERO;
        end else begin
            rdData <= next_rdData;
        end
    end

    wire [NUM_PINS-1:0] next_portDOutputEnable = portDDirection & ~keyPinEnable;

    // direction lags one cycle so the output stays a flop
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            portDOutputEnable <= '0;
        end else begin
            portDOutputEnable <= next_portDOutputEnable;
        end
    end

    // pin sampling and edge detect
    // two-stage synchroniser
    kiu_pin_sync #(
        .WIDTH    (NUM_PINS)
    ) u_sync (
        .clock    (clock),
        .arst_n   (arst_n),
        .pinAsync (portDPin),
        .pinSync  (pinSync)
    );

    wire anyLow   = |(~pinSync & keyPinEnable);
    wire setEvent = anyLow && !anyLowPrev;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            anyLowPrev <= 1'b0;
        end else begin
            anyLowPrev <= anyLow;
        end
    end

    // request latch
    // level hold
    kiu_req_latch u_latch (
        .clock     (clock),
        .arst_n    (arst_n),
        .levelMode (keyLevelSenseSelect),
        .anyLow    (anyLow),
        .setEvent  (setEvent),
        .ackEvent  (ackEvent),
        .keyReq    (keyReq)
    );

    // no clock gating here, so the request also serves as wake-up
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            keyIrq <= 1'b0;
        end else begin
            keyIrq <= keyReq && !keyIrqMask;
        end
    end

    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_disabled_pins_quiet: assert property (
        (keyPinEnable == '0) |-> !anyLow)
        else $error("disabled pins produced a low level");

    a_enable_write_pullup: assert property (
        wrEnable |=> (keyPinEnable == $past(busReq.wdata[NUM_PINS-1:0])))
        else $error("pin enable did not follow write");

    a_fall_latches_req: assert property (
        setEvent |=> keyReq)
        else $error("falling edge did not latch request");

    a_edge_blocked_low: assert property (
        anyLowPrev |-> !setEvent)
        else $error("edge accepted while a pin was low");

    a_level_holds_req: assert property (
        (keyLevelSenseSelect && keyReq && anyLow) |=> keyReq)
        else $error("level request dropped while pin low");

    a_level_both_clear: assert property (
        (keyLevelSenseSelect && keyReq && ackEvent && !anyLow && !setEvent)
        |=> !keyReq)
        else $error("level request not cleared after ack with pins high");

    a_vector_fetch_ack: assert property (
        (vecAck && !keyLevelSenseSelect && !setEvent && !wrStatus) |=> !keyReq)
        else $error("vector fetch did not clear edge request");

    a_status_read_zero: assert property (
        rdStatus |=> (rdData[KIU_UNUSED_MSB:KIU_UNUSED_LSB] == '0) && !rdData[KIU_BIT_ACK])
        else $error("status reserved or acknowledge bit read nonzero");

    a_edge_ack_clear: assert property (
        (swAck && !keyLevelSenseSelect && !busReq.wdata[KIU_BIT_MODE] && !setEvent)
        |=> !keyReq)
        else $error("edge mode acknowledge did not clear request");

    a_pending_flag_read: assert property (
        rdStatus |=> (rdData[KIU_BIT_PEND] == $past(keyReq)))
        else $error("pending flag read mismatch");

    a_break_protects_req: assert property (
        (ackWrite && breakState && !breakClearEnable && !vecAck && keyReq
         && !busReq.wdata[KIU_BIT_MODE] && !keyLevelSenseSelect && !$past(keyLevelSenseSelect)) |=> keyReq)
        else $error("acknowledge in break cleared protected flag");

    a_irq_mask_gate: assert property (
        (keyIrqMask && !wrStatus) |=> ##1 !keyIrq)
        else $error("masked request reached CPU");

    a_irq_follows_req: assert property (
        (keyReq && !keyIrqMask) ##1 (keyReq && !keyIrqMask) |=> keyIrq)
        else $error("unmasked request did not reach CPU");

    a_output_dir_override: assert property (
        ##1 ((portDOutputEnable & $past(keyPinEnable)) == '0))
        else $error("enabled pin still driven as output");

    // reset values checked at the release edge, where the default disable is off
    a_reset_clears_req: assert property (
        @(posedge clock) disable iff (1'b0)
        $rose(arst_n) |-> (!keyReq && !keyLevelSenseSelect && !keyIrqMask && !keyIrq))
        else $error("reset left request or control bits set");

    a_req_needs_edge: assert property (
        $rose(keyReq) |-> $past(setEvent))
        else $error("request rose without a qualifying edge");

    a_break_clear_ack: assert property (
        (swAck && breakState && breakClearEnable && !keyLevelSenseSelect
         && !busReq.wdata[KIU_BIT_MODE] && !setEvent) |=> !keyReq)
        else $error("acknowledge in break with clear enable kept flag");

    a_irq_wake_path: assert property (
        (keyReq && !keyIrqMask) |=> keyIrq)
        else $error("unmasked request did not raise wake-up request");

    c_edge_request: cover property (
        setEvent ##1 keyReq ##[1:20] (ackEvent && !keyLevelSenseSelect));

    c_level_ack_then_high: cover property (
        (keyLevelSenseSelect && keyReq && ackEvent && anyLow) ##[1:50] !keyReq);

    c_break_clear: cover property (
        ackWrite && breakState && breakClearEnable && keyReq);

    c_irq_raised: cover property (
        !keyIrq ##1 keyIrq);

    c_vector_clear: cover property (
        vecAck && keyReq);
endmodule
`default_nettype wire

// ---- kiu_pkg.sv ----
`default_nettype none
package kiu_pkg;

    localparam int KIU_ADDR_W    = 8;
    localparam int KIU_DATA_W    = 8;
    localparam int KIU_PIN_COUNT = 8;
    localparam int KIU_SYNC_LEN  = 2;

    // register offsets
    localparam logic [KIU_ADDR_W-1:0] KIU_OFS_STATUS_CTRL = 8'h1A;
    localparam logic [KIU_ADDR_W-1:0] KIU_OFS_PIN_ENABLE  = 8'h1B;

    // key_status_control field positions
    localparam int KIU_BIT_PEND      = 3;
    localparam int KIU_BIT_ACK       = 2;
    localparam int KIU_BIT_MASK      = 1;
    localparam int KIU_BIT_MODE      = 0;
    localparam int KIU_UNUSED_LSB    = 4;
    localparam int KIU_UNUSED_MSB    = 7;

    localparam logic [KIU_DATA_W-1:0] KIU_RST_STATUS_CTRL = 8'h00;
    localparam logic [KIU_DATA_W-1:0] KIU_RST_PIN_ENABLE  = 8'h00;
    localparam logic [KIU_DATA_W-1:0] KIU_READ_ZERO       = 8'h00;

    // keypad service vector locations
    localparam logic [15:0] KIU_VEC_HI = 16'hFFDE;
    localparam logic [15:0] KIU_VEC_LO = 16'hFFDF;

    typedef struct packed {
        logic [KIU_ADDR_W-1:0] addr;
        logic [KIU_DATA_W-1:0] wdata;
        logic                  wr;
        logic                  rd;
    } kiu_bus_req_t;

    typedef struct packed {
        logic        fetch;
        logic [15:0] addr;
    } kiu_vec_fetch_t;

    typedef enum logic [1:0] {
        KIU_IDLE    = 2'b00,
        KIU_PENDING = 2'b01,
        KIU_ACKED   = 2'b10
    } kiu_req_state_t;

endpackage
`default_nettype wire

// ---- kiu_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module kiu_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] pinAsync,
    output logic      [WIDTH-1:0] pinSync
);
    logic [WIDTH-1:0] stageOne;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("kiu_pin_sync: WIDTH must be at least 1");
        end
    endgenerate

    // first stage feeds only the second
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stageOne <= '1;
            pinSync  <= '1;
        end else begin
            stageOne <= pinAsync;
            pinSync  <= stageOne;
        end
    end
endmodule
`default_nettype wire

// ---- kiu_req_latch.sv ----
`timescale 1ns/1ps
`default_nettype none
module kiu_req_latch
    import kiu_pkg::*;
(
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic levelMode,
    input  wire logic anyLow,
    input  wire logic setEvent,
    input  wire logic ackEvent,
    output logic      keyReq
);
    kiu_req_state_t state;
    kiu_req_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            KIU_IDLE: begin
                if (setEvent) begin
                    next_state = KIU_PENDING;
                end
            end
            KIU_PENDING: begin
                // a new edge beats a simultaneous acknowledge
                if (setEvent) begin
                    next_state = KIU_PENDING;
                end else if (ackEvent) begin
                    next_state = (levelMode && anyLow) ? KIU_ACKED : KIU_IDLE;
                end
            end
            KIU_ACKED: begin
                if (setEvent) begin
                    next_state = KIU_PENDING;
                end else if (!levelMode || !anyLow) begin
                    next_state = KIU_IDLE;
                end
            end
            default: begin
                next_state = KIU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= KIU_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign keyReq = (state != KIU_IDLE);
endmodule
`default_nettype wire

// ---- kiu_keypad_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module kiu_keypad_model (
    input  wire logic       clock,
    input  wire logic [7:0] pullUpEnable,
    input  wire logic [7:0] driveHigh,
    input  wire logic [7:0] pressed,
    output logic      [7:0] pin
);
    logic floatBit = 1'b0;

    // an unpulled, released pin wanders so a stale level is never trusted
    always @(posedge clock) begin
        floatBit <= ~floatBit;
    end

    // an output pin written high reads high
    assign pin = ~pressed & (pullUpEnable | driveHigh | {8{floatBit}});
endmodule
`default_nettype wire

// ---- kiu_keypad_irq_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module kiu_keypad_irq_tb;
    import kiu_pkg::*;
    logic           clock;
    logic           arst_n;
    logic           breakState;
    logic           breakClearEnable;
    logic           keyIrq;
    kiu_bus_req_t   busReq;
    kiu_vec_fetch_t vecFetch;
    logic [7:0]     rdData;
    logic [7:0]     portDPin;
    logic [7:0]     portDDirection;
    logic [7:0]     keyPinEnable;
    logic [7:0]     portDOutputEnable;
    logic [7:0]     pressed;
    int             err_total = 0;
    int             compares = 0;

    kiu_keypad_irq dut_u (
        .clock(clock), .arst_n(arst_n), .busReq(busReq), .rdData(rdData), .vecFetch(vecFetch),
        .breakState(breakState), .breakClearEnable(breakClearEnable), .portDPin(portDPin),
        .portDDirection(portDDirection), .keyPinEnable(keyPinEnable),
        .portDOutputEnable(portDOutputEnable), .keyIrq(keyIrq)
    );
    kiu_keypad_model keys_u (
        .clock(clock), .pullUpEnable(keyPinEnable), .driveHigh(portDOutputEnable),
        .pressed(pressed), .pin(portDPin)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic tally_and_finish();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        busReq <= {a, d, 2'b10};
        @(posedge clock);
        busReq <= {a, d, 2'b00};
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        busReq <= {a, 8'h00, 2'b01};
        @(posedge clock);
        busReq <= {a, 8'h00, 2'b00};
        #1;
        chk(rdData, exp, "read");
    endtask

    // settle waits out the full path so a wrong late change is caught
    task automatic irqChk(input logic exp, input bit settle);
        for (int i = 0; i < 10 && (settle || keyIrq !== exp); i++) begin
            @(posedge clock);
            #1;
        end
        chk({7'h00, keyIrq}, {7'h00, exp}, "keyIrq");
    endtask

    task automatic key(input logic [7:0] p);
        @(posedge clock);
        pressed <= p;
    endtask

    task automatic vec(input logic [15:0] a);
        @(posedge clock);
        vecFetch <= {1'b1, a};
        @(posedge clock);
        vecFetch <= {1'b0, a};
    endtask

    task automatic t_setup();
        rdChk(8'h1A, 8'h00);
        rdChk(8'h1B, 8'h00);
        wr(8'h1C, 8'hFF);
        rdChk(8'h1C, 8'h00);
        wr(8'h1A, 8'h02);
        wr(8'h1B, 8'h03);
        repeat (4) @(posedge clock);
        wr(8'h1A, 8'h06);
        wr(8'h1A, 8'h00);
        chk(keyPinEnable, 8'h03, "pull-up");
        rdChk(8'h1B, 8'h03);
        rdChk(8'h1A, 8'h00);
        @(posedge clock);
        portDDirection <= 8'hFF;
        repeat (3) @(posedge clock);
        chk(portDOutputEnable, 8'hFC, "direction");
        irqChk(1'b0, 1'b1);
    endtask

    task automatic t_edge();
        key(8'h01);
        irqChk(1'b1, 1'b0);
        rdChk(8'h1A, 8'h08);
        wr(8'h1A, 8'h04);
        irqChk(1'b0, 1'b1);
        key(8'h03);
        irqChk(1'b0, 1'b1);
        key(8'h00);
        key(8'h20);
        irqChk(1'b0, 1'b1);
        key(8'h02);
        irqChk(1'b1, 1'b0);
        wr(8'h1A, 8'h04);
        key(8'h00);
        irqChk(1'b0, 1'b1);
    endtask

    task automatic t_mask_vector();
        wr(8'h1A, 8'h02);
        key(8'h01);
        irqChk(1'b0, 1'b1);
        rdChk(8'h1A, 8'h0A);
        wr(8'h1A, 8'h00);
        irqChk(1'b1, 1'b0);
        vec(16'hFFDF);
        irqChk(1'b1, 1'b1);
        vec(16'hFFDE);
        irqChk(1'b0, 1'b1);
        key(8'h00);
    endtask

    task automatic t_level();
        wr(8'h1A, 8'h01);
        key(8'h01);
        irqChk(1'b1, 1'b0);
        wr(8'h1A, 8'h05);
        irqChk(1'b1, 1'b1);
        rdChk(8'h1A, 8'h09);
        key(8'h00);
        irqChk(1'b0, 1'b1);
        key(8'h02);
        irqChk(1'b1, 1'b0);
        key(8'h00);
        irqChk(1'b1, 1'b1);
        wr(8'h1A, 8'h05);
        irqChk(1'b0, 1'b1);
        key(8'h01);
        irqChk(1'b1, 1'b0);
        vec(16'hFFDE);
        irqChk(1'b1, 1'b1);
        key(8'h00);
        irqChk(1'b0, 1'b1);
    endtask

    task automatic t_break();
        wr(8'h1A, 8'h00);
        breakState <= 1'b1;
        key(8'h01);
        irqChk(1'b1, 1'b0);
        wr(8'h1A, 8'h04);
        irqChk(1'b1, 1'b1);
        breakClearEnable <= 1'b1;
        wr(8'h1A, 8'h04);
        irqChk(1'b0, 1'b1);
        breakState <= 1'b0;
        breakClearEnable <= 1'b0;
        irqChk(1'b0, 1'b1);
        key(8'h00);
    endtask

    task automatic t_reset_mid();
        wr(8'h1A, 8'h01);
        key(8'h01);
        irqChk(1'b1, 1'b0);
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (3) @(posedge clock);
        chk({7'h00, keyIrq}, 8'h00, "reset keyIrq");
        arst_n <= 1'b1;
        rdChk(8'h1A, 8'h00);
        rdChk(8'h1B, 8'h00);
        key(8'h00);
        // pins already driven high as outputs, then enabled
        wr(8'h1B, 8'h03);
        repeat (4) @(posedge clock);
        rdChk(8'h1A, 8'h00);
    endtask

    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        arst_n = 1'b0;
        busReq = '0;
        vecFetch = '0;
        breakState = 1'b0;
        breakClearEnable = 1'b0;
        portDDirection = 8'h00;
        pressed = 8'h00;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        t_setup();
        t_edge();
        t_mask_vector();
        t_level();
        t_break();
        t_reset_mid();
        tally_and_finish();
    end
endmodule
`default_nettype wire
